/* logic/tenbt_cfg.svh */
// Timing and pattern constants of the 10 Mb/s twisted-pair core.
`ifndef TENBT_CFG_SVH
`define TENBT_CFG_SVH
// System clock period in nanoseconds.
`define CLK_NS          100
// Squelch qualification window, least gap and link pulse width in ns.
`define SQ_WIN_NS       150
`define SQ_GAP_NS       200
`define LP_WIDTH_NS     100
// Longest window rounds down, least gap rounds up, neither below one cycle.
`define SQ_WIN_CYC      ((`SQ_WIN_NS / `CLK_NS) < 1 ? 1 : (`SQ_WIN_NS / `CLK_NS))
`define SQ_GAP_CYC      ((`SQ_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define LP_WIDTH_CYC    ((`LP_WIDTH_NS + `CLK_NS - 1) / `CLK_NS)
// Jabber, un-jab, link pulse period and link loss times in milliseconds.
`define JAB_MS          24
`define UNJAB_MS        256
`define LP_PERIOD_MS    16
`define LINK_LOSS_MS    100
`define JAB_CYC         (`JAB_MS * 1000000 / `CLK_NS)
`define UNJAB_CYC       (`UNJAB_MS * 1000000 / `CLK_NS)
`define LP_PERIOD_CYC   (`LP_PERIOD_MS * 1000000 / `CLK_NS)
`define LINK_LOSS_CYC   (`LINK_LOSS_MS * 1000000 / `CLK_NS)
// Remote fault idle run of ones, polarity run lengths.
`define REMOTE_FAULT_IDLE_SIGNAL_ONES       84
`define POL_LP_RUN      7
`define POL_PKT_RUN     3
`endif

/* logic/tenbt_pkg.sv */
// Types shared by the 10 Mb/s twisted-pair core and its bench.
`default_nettype none
package tenbt_pkg;
    // Transmit side of the internal media-independent interface.
    typedef struct packed {
        logic en;
        logic d;
    } mii_tx_t;
    // Receive side of the internal media-independent interface.
    typedef struct packed {
        logic crs;
        logic col;
        logic dv;
        logic d;
    } mii_rx_t;
    // Line-side comparator outputs, one bit cell of two halves per clock.
    typedef struct packed {
        logic [1:0] receive_line_pair;
        logic       sq_pos;
        logic       sq_neg;
        logic       lp_pos;
        logic       lp_neg;
        logic       eop_inv;
    } line_in_t;
    // Ability set exchanged by auto-negotiation.
    typedef struct packed {
        logic tx_fd;
        logic tx_hd;
        logic t_fd;
        logic t_hd;
    } abil_t;
    // Squelch qualification states, Gray coded along the path.
    typedef enum logic [1:0] {
        SQ_IDLE  = 2'h0,
        SQ_ARMED = 2'h1,
        SQ_OPP   = 2'h3,
        SQ_VALID = 2'h2
    } sq_state_t;
    // Resolved operating mode.
    typedef enum logic [2:0] {
        AN_NONE  = 3'h0,
        AN_TX_FD = 3'h1,
        AN_TX_HD = 3'h2,
        AN_T_FD  = 3'h3,
        AN_T_HD  = 3'h4
    } an_mode_t;
endpackage
`default_nettype wire

/* logic/tenbt_phy_core.sv */
// Digital core of one 10 Mb/s twisted-pair port with fiber fault idle and mode resolution.
//
// Contract
// R1: fiber remote fault idle is 84 ones, one zero.
// R2: half duplex: collision incl. jabber, carrier on both.
// R3: full duplex: simultaneous traffic is no collision.
// R4: encode while enable high and link good.
// R5: last transition mid-cell for one, boundary for zero.
// R6: carrier drops when mid-bit transitions stop.
// R7: squelch needs first, opposite, first within windows.
// R8: valid data ends after squelch gap over 200 ns.
// R9: thresholds lowered for rest of packet.
// R10: long-cable option lowers receive squelch threshold.
// R11: carrier follows receive only in full or repeater.
// R12: enable held over 24 ms locks transmitter off.
// R13: unlock after 256 ms with enable low.
// R14: jabber protection can be switched off.
// R15: no link pulses disables transmit, receive, collision.
// R16: idle line gets one-cycle link pulse every 16 ms.
// R17: seven inverted pulses or three packets mean reversed.
// R18: resolve 100 full, 100 half, 10 full, 10 half.
// R19: reversed polarity inverts data before decoding.
`include "tenbt_cfg.svh"
`default_nettype none
module tenbt_phy_core
    import tenbt_pkg::*;
#(
    parameter logic [21:0] JAB_CYC       = 22'(`JAB_CYC),
    parameter logic [21:0] UNJAB_CYC     = 22'(`UNJAB_CYC),
    parameter logic [17:0] LP_PERIOD_CYC = 18'(`LP_PERIOD_CYC),
    parameter logic [20:0] LINK_LOSS_CYC = 21'(`LINK_LOSS_CYC)
)(
    // Clock and reset.
    input  wire logic     clk_sys,
    input  wire logic     nrst,
    // Internal media-independent interface.
    input  wire mii_tx_t  mii_tx,
    output var  mii_rx_t  mii_rx,
    // Line side.
    input  wire line_in_t line_in,
    output logic [1:0]    tx_cell,
    output logic          tx_drive,
    output logic          sq_low_thr,
    output logic          remote_fault_idle_signal,
    // Configuration.
    input  wire logic     full_duplex,
    input  wire logic     repeater_mode,
    input  wire logic     long_cable,
    input  wire logic     jabber_off,
    input  wire logic     fx_mode,
    input  wire logic     remote_fault,
    input  wire abil_t    local_abil,
    input  wire abil_t    partner_abil,
    // Status.
    output logic          pol_reversed,
    output logic          link_good,
    output logic          jabber_locked,
    output an_mode_t      an_mode
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    line_in_t    s1_reg;          // First stage, read only by the second.
    line_in_t    s2_reg;          // Second stage, safe to use.
    line_in_t    s3_reg;          // Delayed copy for edge detection.
    logic        lp_pos_rise;     // Positive link pulse seen.
    logic        lp_neg_rise;     // Negative link pulse seen.
    logic        any_sq;          // Either squelch comparator active.

    // Line comparators are asynchronous to clk_sys, hence two flops first.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= line_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign lp_pos_rise = s2_reg.lp_pos & ~s3_reg.lp_pos;
    assign lp_neg_rise = s2_reg.lp_neg & ~s3_reg.lp_neg;
    assign any_sq      = s2_reg.sq_pos | s2_reg.sq_neg;

    // ****************************************
    // State declarations
    // ****************************************
    logic        link_reg, link_next;         // Link integrity good.
    logic [20:0] loss_reg, loss_next;         // Time since last link evidence.
    logic        jab_reg, jab_next;           // Transmitter locked by jabber.
    logic [21:0] jcnt_reg, jcnt_next;         // Jabber and un-jab timer.
    logic [1:0]  cell_reg, cell_next;         // Outgoing bit cell halves.
    logic        drv_reg, drv_next;           // Line driver enabled.
    logic        last_reg, last_next;         // Last transmitted bit.
    logic        tail_reg, tail_next;         // Frame just sent, tail pending.
    logic [17:0] lp_cnt_reg, lp_cnt_next;     // Link pulse period timer.
    sq_state_t   sq_reg, sq_next;             // Squelch qualification state.
    logic [1:0]  win_reg, win_next;           // Cycles spent in a window.
    logic [1:0]  gap_reg, gap_next;           // Cycles without squelch.
    logic        car_reg, car_next;           // Decoded receive carrier.
    logic        rxd_reg, rxd_next;           // Decoded receive bit.
    logic        pol_reg, pol_next;           // Receive polarity reversed.
    logic [2:0]  inv_run_reg, inv_run_next;   // Run of inverted link pulses.
    logic [2:0]  nrm_run_reg, nrm_run_next;   // Run of normal link pulses.
    logic [1:0]  pkt_run_reg, pkt_run_next;   // Run of inverted end pulses.
    logic        crs_reg, crs_next;           // Carrier sense to the MAC.
    logic        col_reg, col_next;           // Collision to the MAC.
    logic        remote_fault_idle_signal_reg, remote_fault_idle_signal_next;         // Fiber idle bit.
    logic [6:0]  fcnt_reg, fcnt_next;         // Position in the idle group.
    an_mode_t    an_reg, an_next;             // Resolved mode.
    logic        tx_act;                      // Frame bits are being encoded.
    logic        first_x;                     // First-polarity crossing.
    logic        opp_x;                       // Opposite-polarity crossing.
    logic        frame_end;                   // Receive carrier falls now.
    abil_t       common;                      // Abilities both ends share.

    // Encoding needs a good link and no jabber lockout.
    assign tx_act = mii_tx.en & link_reg & ~jab_reg; // see R4 R15

    // ****************************************
    // Link integrity and jabber
    // ****************************************
    // Link evidence is any link pulse or decoded carrier; loss saturates.
    always_comb begin
        link_next = link_reg;
        loss_next = loss_reg;
        if (lp_pos_rise || lp_neg_rise || car_reg) begin
            link_next = 1'b1;
            loss_next = '0;
        end else if (loss_reg == LINK_LOSS_CYC - 21'h1) begin
            link_next = 1'b0; // see R15
        end else begin
            loss_next = loss_reg + 21'h1;
        end
        // One counter serves both jabber and un-jab; they never overlap.
        jab_next  = jab_reg;
        jcnt_next = '0;
        if (jabber_off) begin
            jab_next = 1'b0; // see R14
        end else if (!jab_reg) begin
            if (mii_tx.en && jcnt_reg == JAB_CYC) begin
                jab_next = 1'b1; // see R12
            end else if (mii_tx.en) begin
                jcnt_next = jcnt_reg + 22'h1;
            end
        end else if (!mii_tx.en) begin
            if (jcnt_reg == UNJAB_CYC - 22'h1) begin
                jab_next = 1'b0; // see R13
            end else begin
                jcnt_next = jcnt_reg + 22'h1;
            end
        end
    end

    // ****************************************
    // Manchester encoder and link pulses
    // ****************************************
    // A one is low then high; the tail adds the boundary step after a zero.
    always_comb begin
        cell_next   = 2'h0;
        drv_next    = 1'b0;
        last_next   = last_reg;
        tail_next   = 1'b0;
        lp_cnt_next = lp_cnt_reg + 18'h1;
        if (tx_act) begin
            cell_next   = {~mii_tx.d, mii_tx.d}; // see R4
            drv_next    = 1'b1;
            last_next   = mii_tx.d;
            tail_next   = 1'b1;
            lp_cnt_next = '0;
        end else if (tail_reg && !last_reg) begin
            cell_next   = 2'h3; // see R5
            drv_next    = 1'b1;
            lp_cnt_next = '0;
        end else if (tail_reg) begin
            lp_cnt_next = '0; // see R5
        end else if (lp_cnt_reg == LP_PERIOD_CYC - 18'h1) begin
            cell_next   = 2'h3; // see R16
            drv_next    = 1'b1;
            lp_cnt_next = '0;
        end
    end

    // ****************************************
    // Squelch, decoder and polarity
    // ****************************************
    // Which comparator counts as first depends on the corrected polarity.
    assign first_x = pol_reg ? s2_reg.sq_neg : s2_reg.sq_pos;
    assign opp_x   = pol_reg ? s2_reg.sq_pos : s2_reg.sq_neg;

    always_comb begin
        sq_next  = sq_reg;
        win_next = '0;
        gap_next = '0;
        case (sq_reg)
            // Pulses that never reach the first threshold are ignored.
            SQ_IDLE: begin
                if (first_x && link_reg) begin
                    sq_next = SQ_ARMED; // see R7 R15
                end
            end
            // The opposite threshold must follow inside the window.
            SQ_ARMED: begin
                if (opp_x) begin
                    sq_next = SQ_OPP;
                end else if (win_reg + 2'h1 >= 2'(`SQ_WIN_CYC)) begin
                    sq_next = SQ_IDLE; // see R7
                end else begin
                    win_next = win_reg + 2'h1;
                end
            end
            // Then the first threshold again inside a further window.
            SQ_OPP: begin
                if (first_x) begin
                    sq_next = SQ_VALID; // see R7
                end else if (win_reg + 2'h1 >= 2'(`SQ_WIN_CYC)) begin
                    sq_next = SQ_IDLE;
                end else begin
                    win_next = win_reg + 2'h1;
                end
            end
            // Valid until the squelch gap exceeds the least gap.
            SQ_VALID: begin
                gap_next = any_sq ? 2'h0 : (gap_reg == 2'h3 ? 2'h3 : gap_reg + 2'h1);
                if (!link_reg || gap_next > 2'(`SQ_GAP_CYC)) begin
                    sq_next = SQ_IDLE; // see R8
                end
            end
            default: begin
                sq_next = SQ_IDLE;
            end
        endcase
    end

    // Carrier lasts while cells carry a mid-bit transition.
    assign car_next  = (sq_reg == SQ_VALID) && link_reg &&
                       (s2_reg.receive_line_pair[1] != s2_reg.receive_line_pair[0]); // see R6
    assign rxd_next  = s2_reg.receive_line_pair[0] ^ pol_reg; // see R19
    assign frame_end = car_reg & ~car_next;

    // Runs are consecutive: a pulse of the other sense restarts them.
    always_comb begin
        pol_next     = pol_reg;
        inv_run_next = inv_run_reg;
        nrm_run_next = nrm_run_reg;
        pkt_run_next = pkt_run_reg;
        if (lp_neg_rise) begin
            inv_run_next = inv_run_reg + 3'h1;
            nrm_run_next = '0;
            if (inv_run_next == 3'(`POL_LP_RUN)) begin
                pol_next     = 1'b1; // see R17
                inv_run_next = '0;
            end
        end else if (lp_pos_rise) begin
            nrm_run_next = nrm_run_reg + 3'h1;
            inv_run_next = '0;
            if (nrm_run_next == 3'(`POL_LP_RUN)) begin
                pol_next     = 1'b0; // see R17
                nrm_run_next = '0;
            end
        end
        if (frame_end) begin
            pkt_run_next = s2_reg.eop_inv ? pkt_run_reg + 2'h1 : 2'h0;
            if (pkt_run_next == 2'(`POL_PKT_RUN)) begin
                pol_next     = 1'b1; // see R17
                pkt_run_next = '0;
            end
        end
    end

    // ****************************************
    // MAC status, fiber idle and mode resolution
    // ****************************************
    assign common = local_abil & partner_abil;

    always_comb begin
        // Transmit counts toward carrier only in plain half duplex.
        crs_next = link_reg & (car_next |
                   (~full_duplex & ~repeater_mode & tx_act)); // see R2 R11
        col_next = ~full_duplex & link_reg &
                   ((tx_act & car_reg) | (jab_reg & mii_tx.en)); // see R2 R3
        // Idle group is ones then a single zero while the fault stands.
        remote_fault_idle_signal_next = 1'b1;
        fcnt_next = '0;
        if (fx_mode && remote_fault) begin
            remote_fault_idle_signal_next = (fcnt_reg != 7'(`REMOTE_FAULT_IDLE_SIGNAL_ONES)); // see R1
            fcnt_next = (fcnt_reg == 7'(`REMOTE_FAULT_IDLE_SIGNAL_ONES)) ? 7'h0 : fcnt_reg + 7'h1;
        end
        if (common.tx_fd) begin
            an_next = AN_TX_FD; // see R18
        end else if (common.tx_hd) begin
            an_next = AN_TX_HD;
        end else if (common.t_fd) begin
            an_next = AN_T_FD;
        end else if (common.t_hd) begin
            an_next = AN_T_HD;
        end else begin
            an_next = AN_NONE;
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    // Every group but the pin synchronisers registers here; the link starts down after reset.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            link_reg    <= 1'b0;
            loss_reg    <= '0;
            jab_reg     <= 1'b0;
            jcnt_reg    <= '0;
            cell_reg    <= 2'h0;
            drv_reg     <= 1'b0;
            last_reg    <= 1'b0;
            tail_reg    <= 1'b0;
            lp_cnt_reg  <= '0;
            sq_reg      <= SQ_IDLE;
            win_reg     <= '0;
            gap_reg     <= '0;
            car_reg     <= 1'b0;
            rxd_reg     <= 1'b0;
            pol_reg     <= 1'b0;
            inv_run_reg <= '0;
            nrm_run_reg <= '0;
            pkt_run_reg <= '0;
            crs_reg     <= 1'b0;
            col_reg     <= 1'b0;
            remote_fault_idle_signal_reg    <= 1'b1;
            fcnt_reg    <= '0;
            an_reg      <= AN_NONE;
        end else begin
            link_reg    <= link_next;
            loss_reg    <= loss_next;
            jab_reg     <= jab_next;
            jcnt_reg    <= jcnt_next;
            cell_reg    <= cell_next;
            drv_reg     <= drv_next;
            last_reg    <= last_next;
            tail_reg    <= tail_next;
            lp_cnt_reg  <= lp_cnt_next;
            sq_reg      <= sq_next;
            win_reg     <= win_next;
            gap_reg     <= gap_next;
            car_reg     <= car_next;
            rxd_reg     <= rxd_next;
            pol_reg     <= pol_next;
            inv_run_reg <= inv_run_next;
            nrm_run_reg <= nrm_run_next;
            pkt_run_reg <= pkt_run_next;
            crs_reg     <= crs_next;
            col_reg     <= col_next;
            remote_fault_idle_signal_reg    <= remote_fault_idle_signal_next;
            fcnt_reg    <= fcnt_next;
            an_reg      <= an_next;
        end
    end

    // Thresholds drop for the packet body or for long cables.
    assign sq_low_thr    = (sq_reg == SQ_VALID) | long_cable; // see R9 R10
    assign mii_rx        = '{crs: crs_reg, col: col_reg, dv: car_reg, d: rxd_reg};
    assign tx_cell       = cell_reg;
    assign tx_drive      = drv_reg;
    assign remote_fault_idle_signal = remote_fault_idle_signal_reg;
    assign pol_reversed  = pol_reg;
    assign link_good     = link_reg;
    assign jabber_locked = jab_reg;
    assign an_mode       = an_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence opp_seen_s;
        sq_reg == SQ_ARMED ##1 sq_reg == SQ_OPP;
    endsequence
    sequence qualified_s;
        sq_reg == SQ_OPP ##1 sq_reg == SQ_VALID;
    endsequence

    squelch_qual_a: assert property ($rose(sq_reg == SQ_VALID) |-> $past(sq_reg) == SQ_OPP) // see R7
        else $error("valid data without full squelch sequence");
    squelch_path_a: assert property (opp_seen_s |-> $past(first_x, 2) || $past(sq_reg, 2) != SQ_IDLE) // see R7
        else $error("squelch armed without first crossing");
    squelch_gap_a: assert property ((sq_reg == SQ_VALID && !any_sq)[*3] |=> sq_reg != SQ_VALID) // see R8
        else $error("valid data outlived squelch gap");
    low_thresh_a: assert property (qualified_s |-> sq_low_thr) // see R9
        else $error("thresholds not lowered after qualification");
    long_cable_a: assert property (long_cable |-> sq_low_thr) // see R10
        else $error("long cable threshold not applied");
    carrier_drop_a: assert property (car_reg && s2_reg.receive_line_pair[1] ==
                                     s2_reg.receive_line_pair[0] |=> !car_reg) // see R6
        else $error("carrier held without mid-bit transition");
    crs_rx_only_a: assert property ((full_duplex || repeater_mode) && !car_next |=> !mii_rx.crs) // see R11
        else $error("carrier sense from transmit outside half duplex");
    crs_tx_a: assert property (!full_duplex && !repeater_mode && tx_act |=> mii_rx.crs) // see R2
        else $error("no carrier sense while transmitting");
    col_half_a: assert property (!full_duplex && tx_act && car_reg |=> mii_rx.col) // see R2
        else $error("collision missed in half duplex");
    no_col_full_a: assert property (full_duplex |=> !mii_rx.col || !$past(full_duplex, 2)) // see R3
        else $error("collision reported in full duplex");
    encode_a: assert property (tx_act |=> tx_drive && tx_cell == {~$past(mii_tx.d), $past(mii_tx.d)}) // see R4
        else $error("bit not encoded while enabled");
    tail_zero_a: assert property (tail_reg && !last_reg && !tx_act |=> tx_drive && tx_cell == 2'h3 ##1 !tail_reg) // see R5
        else $error("boundary step missing after final zero");
    jab_lock_a: assert property ($rose(jab_reg) |-> $past(jcnt_reg) == JAB_CYC && $past(mii_tx.en)) // see R12
        else $error("jabber lock at wrong time");
    jab_hold_a: assert property (jab_reg && mii_tx.en && !jabber_off |=> jab_reg) // see R12
        else $error("jabber released while enable high");
    unjab_a: assert property ($fell(jab_reg) && !$past(jabber_off) |-> $past(jcnt_reg) == UNJAB_CYC - 22'h1) // see R13
        else $error("transmitter re-enabled early");
    jab_off_a: assert property (jabber_off |=> !jab_reg) // see R14
        else $error("jabber active while disabled");
    link_gate_a: assert property (!link_reg |=> !mii_rx.dv && !mii_rx.col) // see R15
        else $error("receive or collision without link");
    link_pulse_a: assert property (!tx_act && !tail_reg && lp_cnt_reg == LP_PERIOD_CYC - 18'h1
                                   |=> tx_drive && tx_cell == 2'h3 && lp_cnt_reg == 18'h0) // see R16
        else $error("link pulse not emitted on period");
    pol_set_a: assert property ($rose(pol_reg) |-> $past(inv_run_reg) == 3'h6 || $past(pkt_run_reg) == 2'h2) // see R17
        else $error("polarity reversed without enough evidence");
    pol_data_a: assert property (car_reg |-> rxd_reg == ($past(s2_reg.receive_line_pair[0]) ^ $past(pol_reg))) // see R19
        else $error("received data not polarity corrected");
    remote_fault_idle_signal_zero_a: assert property (fx_mode && remote_fault && fcnt_reg == 7'h54 |=> !remote_fault_idle_signal) // see R1
        else $error("fault idle zero missing");
    an_prio_a: assert property (common.tx_fd |=> an_mode == AN_TX_FD) // see R18
        else $error("highest common mode not chosen");
endmodule
`default_nettype wire

/* verification/line_partner.sv */
// Link partner model driving the line-side comparator inputs.
`default_nettype none
module line_partner
    import tenbt_pkg::*;
(
    // Clock and pulse polarity.
    input  wire logic   clk_sys,
    input  wire logic   inv,
    // Line side.
    output var line_in_t line_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt = 5'h00; // Spacing of link pulses.
    // A pulse every 32 cycles keeps the link alive well inside the loss time.
    // Idle halves alternate but never differ within a cell, so no data is seen.
    always @(negedge clk_sys) begin
        cnt <= cnt + 5'h01;
        line_in <= '{receive_line_pair: {2{cnt[0]}}, lp_pos: (cnt == 5'h00) && !inv,
                     lp_neg: (cnt == 5'h00) && inv, default: 1'b0};
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench of the 10 Mb/s twisted-pair core.
`default_nettype none
module tb_top;
    import tenbt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic full_duplex = 1'b0;
    logic fx_mode = 1'b0;
    logic remote_fault = 1'b0;
    logic inv = 1'b0;
    logic long_cable = 1'b0;
    logic jabber_off = 1'b0;
    mii_tx_t mii_tx = '0;
    abil_t local_abil = '0;
    abil_t partner_abil = '0;
    mii_rx_t mii_rx;
    line_in_t line_in;
    an_mode_t an_mode;
    logic [1:0] tx_cell;
    logic tx_drive, sq_low_thr, rfi_bit, pol_reversed, link_good, jabber_locked;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int zeros = 0;
    // Resolution table: local and partner abilities beside the mode they give.
    logic [3:0] loc [5] = '{4'hf, 4'h7, 4'h3, 4'h9, 4'h8};
    logic [3:0] par [5] = '{4'hf, 4'h6, 4'hb, 4'h5, 4'h4};
    an_mode_t res [5] = '{AN_TX_FD, AN_TX_HD, AN_T_FD, AN_T_HD, AN_NONE};
    tenbt_phy_core #(.JAB_CYC(22'd40), .UNJAB_CYC(22'd60), .LP_PERIOD_CYC(18'd50),
        .LINK_LOSS_CYC(21'd400)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .mii_tx(mii_tx),
        .mii_rx(mii_rx), .line_in(line_in), .tx_cell(tx_cell), .tx_drive(tx_drive),
        .sq_low_thr(sq_low_thr), .remote_fault_idle_signal(rfi_bit),
        .full_duplex(full_duplex), .repeater_mode(1'b0), .long_cable(long_cable),
        .jabber_off(jabber_off), .fx_mode(fx_mode), .remote_fault(remote_fault),
        .local_abil(local_abil), .partner_abil(partner_abil), .pol_reversed(pol_reversed),
        .link_good(link_good), .jabber_locked(jabber_locked), .an_mode(an_mode));
    line_partner i_partner (.clk_sys(clk_sys), .inv(inv), .line_in(line_in));
    // Compare and count; a mismatch is printed at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // A hang is cut short well past the expected run length.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        check(8'({mii_rx, link_good, jabber_locked, pol_reversed, tx_drive}), 8'h00);
        check(8'(rfi_bit), 8'h01);
        nrst = 1'b1;
        for (int i = 0; i < 5; i++) begin
            local_abil = loc[i];
            partner_abil = par[i];
            repeat (3) @(negedge clk_sys);
            check(8'(an_mode), 8'(res[i]));
        end
        fx_mode = 1'b1;
        remote_fault = 1'b1;
        repeat (200) begin
            @(negedge clk_sys);
            zeros += int'(rfi_bit === 1'b0);
        end
        check(8'(zeros), 8'h02);
        repeat (40) @(negedge clk_sys);
        check(8'(link_good), 8'h01);
        mii_tx = '{en: 1'b1, d: 1'b1};
        repeat (2) @(negedge clk_sys);
        check(8'({tx_drive, tx_cell}), 8'h05);
        check(8'(mii_rx.crs), 8'h01);
        repeat (50) @(negedge clk_sys);
        check(8'({jabber_locked, mii_rx.col, tx_drive}), 8'h06);
        mii_tx = '0;
        repeat (30) @(negedge clk_sys);
        check(8'(jabber_locked), 8'h01);
        repeat (40) @(negedge clk_sys);
        check(8'(jabber_locked), 8'h00);
        // Full duplex, long cable and jabber off together over a long transmit.
        full_duplex = 1'b1;
        long_cable = 1'b1;
        jabber_off = 1'b1;
        mii_tx = '{en: 1'b1, d: 1'b0};
        repeat (50) @(negedge clk_sys);
        check(8'({mii_rx.crs, mii_rx.col, jabber_locked, sq_low_thr, tx_drive}), 8'h03);
        mii_tx = '0;
        full_duplex = 1'b0;
        long_cable = 1'b0;
        jabber_off = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(8'(sq_low_thr), 8'h00);
        inv = 1'b1;
        repeat (264) @(negedge clk_sys);
        check(8'(pol_reversed), 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
